/* dv/rsdir_assertions.sv */
`timescale 1ns/1ps
// Direction control checker.
module rsdir_chk(input wire logic clock,rst,busWrite,busRead,busPort,busRdValid,
  input wire logic [2:0] busAddr,input wire logic [7:0] busWrData,
  input wire logic [1:0] dtrN,txEnable,rxEnable,uart_transmit_ready_out,
  automatic_direction_control);
  wire u=automatic_direction_control[0],t=uart_transmit_ready_out[0],r=busRead&&busAddr==7;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  a_auto_tx: assert property (u|->txEnable[0]==t) else $error("auto tx");
  a_auto_rx: assert property (u|->!(txEnable[0]&&rxEnable[0])) else $error("auto rx");
  a_reset_on: assert property ($past(rst)|->(txEnable&rxEnable)==3) else $error("rst");
  a_dtr_rx: assert property (!u&&!dtrN[0]|->rxEnable[0]) else $error("dtr rx");
  a_dtr_tx: assert property (!u&&dtrN[0]|->txEnable[0]) else $error("dtr tx");
  a_rd_ack: assert property (r|=>busRdValid) else $error("rd ack");
  a_rd_none: assert property (!r|=>!busRdValid) else $error("rd stray");
  a_wr_now: assert property (busWrite&&busAddr==7&&!busPort&&busWrData==3|=>u)
    else $error("wr late");
endmodule
bind rsdir_transceiver_ctrl rsdir_chk c_u(.*);

/* dv/rsdir_transceiver_ctrl_tb.sv */
`timescale 1ns/1ps
// Direction control bench.
module rsdir_transceiver_ctrl_tb;
  logic clock=0,rst=1,busWrite=0,busRead=0,busPort=0,busRdValid,rxd,tx,rx;
  logic [2:0] busAddr=0;
  logic [7:0] busWrData=0,busRdData;
  logic [1:0] dtrN=3,t=0,txEnable,rxEnable,au;
  int errors=0,n_checks=0;
  always #4 clock=~clock;
  rsdir_transceiver_ctrl dut_u(.*,.uart_transmit_ready_out(t),.automatic_direction_control(au));
  rsdir_xcvr x_u(.txEn(txEnable[0]),.rxEn(rxEnable[0]),.txd(1'b0),.lineIn(1'b1),.rxd);
  task automatic chk(string n,logic [7:0] e,s);
    n_checks++;
    if(s!==e) begin
      errors++;
      $display("mismatch %s exp %h got %h",n,e,s);
    end
  endtask
  task automatic cyc(logic w,r,p,logic [2:0] a,logic [7:0] d);
    @(posedge clock) #1;
    {busWrite,busRead,busPort,busAddr,busWrData}={w,r,p,a,d};
    @(posedge clock) #1;
    {busWrite,busRead}=0;
  endtask
  task automatic mode(logic [7:0] c);
    cyc(1,0,0,7,c);
    cyc(0,1,0,7,0);
    chk("rd",c,busRdValid?busRdData:8'hEE);
    for(int i=0;i<4;i++) begin
      @(posedge clock) #1 {dtrN[0],t[0]}=i[1:0];
      #1 tx=c==3?t[0]:c==0||c>3||dtrN[0];
      rx=c==3?!t[0]:c!=2||!dtrN[0];
      chk("en",{tx,rx},{txEnable[0],rxEnable[0]});
      chk("echo",!(tx&rx),rxd);
    end
  endtask
  task automatic mid_reset;
    cyc(1,0,0,7,8'h02);
    cyc(1,0,1,7,8'h03);
    @(posedge clock) #1 rst=1;
    @(posedge clock) #1 rst=0;
    chk("rst_en",3,txEnable&rxEnable);
    chk("rst_au",0,au);
    cyc(0,1,0,7,0);
    chk("rst_rd",8'h00,busRdValid?busRdData:8'hEE);
    cyc(0,1,1,7,0);
    chk("rst_rd1",8'h00,busRdValid?busRdData:8'hEE);
  endtask
  task automatic final_report;
    $display("checks %0d errors %0d",n_checks,errors);
    if(errors==0&&n_checks>0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat(3) @(posedge clock);
    #1 rst=0;
    chk("rst",3,txEnable&rxEnable);
    for(int k=0;k<5;k++) mode(k<4?8'(3-k):8'hA5);
    cyc(1,0,0,6,3);
    cyc(0,1,0,6,0);
    chk("off",0,{au,busRdValid});
    cyc(1,0,1,7,3);
    chk("au",2,au);
    mid_reset;
    final_report;
  end
endmodule

/* dv/rsdir_xcvr.sv */
`timescale 1ns/1ps
// Line transceiver model whose receiver output floats high when off.
module rsdir_xcvr(input wire logic txEn,rxEn,txd,lineIn,output logic rxd);
  assign rxd=rxEn?(txEn?txd:lineIn):1'b1;
endmodule

/* verilog/rsdir_mode_mem.sv */
`timescale 1ns/1ps
// Per-port mode byte storage with registered read data.
module rsdir_mode_mem
  import rsdir_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic writeEn,
  input wire logic [RSDIR_PORT_W-1:0] writePort,
  input wire logic [7:0] writeData,
  input wire logic [RSDIR_PORT_W-1:0] readPort,
  output logic [7:0] readData,
  output logic [RSDIR_NUM_PORTS*8-1:0] allModes
);
  logic [7:0] mem_r [RSDIR_NUM_PORTS];

  always_ff @(posedge clock) begin
    for (int i = 0; i < RSDIR_NUM_PORTS; i++) begin
      if (rst) begin
        mem_r[i] <= RSDIR_MODE_SEL_RESET;
      end else if (writeEn && writePort == i[RSDIR_PORT_W-1:0]) begin
        mem_r[i] <= writeData;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      readData <= RSDIR_MODE_SEL_RESET;
    end else begin
      readData <= mem_r[readPort];
    end
  end

  always_comb begin
    for (int i = 0; i < RSDIR_NUM_PORTS; i++) begin
      allModes[i*8 +: 8] = mem_r[i];
    end
  end
endmodule

/* verilog/rsdir_pkg.sv */
// Package with register offsets, mode codes and reset values for the RS-485 direction control.
package rsdir_pkg;
  localparam int RSDIR_ADDR_W = 3;
  localparam int RSDIR_DATA_W = 8;
  localparam logic [2:0] RSDIR_MODE_SEL_OFFSET = 3'h7;
  localparam logic [7:0] RSDIR_MODE_FOUR_WIRE = 8'h00;
  localparam logic [7:0] RSDIR_MODE_DTR_ECHO = 8'h01;
  localparam logic [7:0] RSDIR_MODE_DTR_CTRL = 8'h02;
  localparam logic [7:0] RSDIR_MODE_AUTO = 8'h03;
  localparam logic [7:0] RSDIR_MODE_SEL_RESET = 8'h00;
  localparam int RSDIR_NUM_PORTS = 2;
  localparam int RSDIR_PORT_W = 1;

  typedef enum logic [3:0] {
    RSDIR_FOUR_WIRE = 4'h1,
    RSDIR_DTR_ECHO = 4'h2,
    RSDIR_DTR_CTRL = 4'h4,
    RSDIR_AUTO = 4'h8
  } rsdir_mode_t;
endpackage

/* verilog/rsdir_transceiver_ctrl.sv */
`timescale 1ns/1ps
// RS-485 transceiver direction control behind the UART register window.
module rsdir_transceiver_ctrl
  import rsdir_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic busWrite,
  input wire logic busRead,
  input wire logic [RSDIR_PORT_W-1:0] busPort,
  input wire logic [RSDIR_ADDR_W-1:0] busAddr,
  input wire logic [RSDIR_DATA_W-1:0] busWrData,
  output logic [RSDIR_DATA_W-1:0] busRdData,
  output logic busRdValid,
  input wire logic [RSDIR_NUM_PORTS-1:0] dtrN,
  input wire logic [RSDIR_NUM_PORTS-1:0] uart_transmit_ready_out,
  output logic [RSDIR_NUM_PORTS-1:0] txEnable,
  output logic [RSDIR_NUM_PORTS-1:0] rxEnable,
  output logic [RSDIR_NUM_PORTS-1:0] automatic_direction_control
);
  // Decodes a mode byte; codes above the four defined ones fall back to four-wire.
  function automatic rsdir_mode_t decodeMode(input logic [7:0] code);
    case (code)
      RSDIR_MODE_FOUR_WIRE: decodeMode = RSDIR_FOUR_WIRE;
      RSDIR_MODE_DTR_ECHO: decodeMode = RSDIR_DTR_ECHO;
      RSDIR_MODE_DTR_CTRL: decodeMode = RSDIR_DTR_CTRL;
      RSDIR_MODE_AUTO: decodeMode = RSDIR_AUTO;
      default: decodeMode = RSDIR_FOUR_WIRE;
    endcase
  endfunction

  wire logic modeSelHit;
  wire logic modeWrite;
  wire logic [RSDIR_NUM_PORTS*8-1:0] allModes;
  wire logic [7:0] memRdData;
  logic busRdValid_r;

  assign modeSelHit = (busAddr == RSDIR_MODE_SEL_OFFSET);
  assign modeWrite = busWrite && modeSelHit;

  rsdir_mode_mem u_modeMem (
    .clock(clock),
    .rst(rst),
    .writeEn(modeWrite),
    .writePort(busPort),
    .writeData(busWrData),
    .readPort(busPort),
    .readData(memRdData),
    .allModes(allModes)
  );

  always_ff @(posedge clock) begin
    if (rst) begin
      busRdValid_r <= 1'b0;
    end else begin
      busRdValid_r <= busRead && modeSelHit;
    end
  end

  assign busRdValid = busRdValid_r;
  assign busRdData = busRdValid_r ? memRdData : 8'h00;

  // Enables are decoded straight from the stored byte, so a write acts next cycle.
  always_comb begin
    for (int p = 0; p < RSDIR_NUM_PORTS; p++) begin
      rsdir_mode_t m;
      m = decodeMode(allModes[p*8 +: 8]);
      automatic_direction_control[p] = (m == RSDIR_AUTO);
      case (m)
        RSDIR_FOUR_WIRE: begin
          txEnable[p] = 1'b1;
          rxEnable[p] = 1'b1;
        end
        RSDIR_DTR_ECHO: begin
          txEnable[p] = dtrN[p];
          rxEnable[p] = 1'b1;
        end
        RSDIR_DTR_CTRL: begin
          txEnable[p] = dtrN[p];
          rxEnable[p] = ~dtrN[p];
        end
        RSDIR_AUTO: begin
          txEnable[p] = uart_transmit_ready_out[p];
          rxEnable[p] = ~uart_transmit_ready_out[p];
        end
        default: begin
          txEnable[p] = 1'b1;
          rxEnable[p] = 1'b1;
        end
      endcase
    end
  end
endmodule
